/* core/rfxc_fbdiv.sv */
// Synthesizer feedback divider, ratio 16 or 22 by band
`timescale 1ns/10ps
`default_nettype none
module rfxc_fbdiv (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic band_315,
    output logic      fb_pulse
);
    localparam logic [4:0] LAST_315 = 5'(rfxc_pkg::DIV_315 - 1);
    localparam logic [4:0] LAST_434 = 5'(rfxc_pkg::DIV_434 - 1);

    logic [rfxc_pkg::DIV_W-1:0] cnt_ff;
    logic [rfxc_pkg::DIV_W-1:0] last;
    logic                       pulse_ff;

    assign last = band_315 ? LAST_315 : LAST_434;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_ff   <= '0;
            pulse_ff <= 1'b0;
        end else if (cnt_ff >= last) begin
            cnt_ff   <= '0;
            pulse_ff <= 1'b1;
        end else begin
            cnt_ff   <= cnt_ff + 5'h01;
            pulse_ff <= 1'b0;
        end
    end

    assign fb_pulse = pulse_ff;
endmodule
`default_nettype wire

/* core/rfxc_pkg.sv */
// Package with register map, field positions, reset values and timing for the crystal and RF PA register bank
// Functional notes
// - Four-bit crystal bias code at 0x86
// - Bias bits 3:0 write-only, clear on resets
// - Crystal running flag, status 0xe3 bit 4
// - VCO gain indicator in status bit 3
// - Lock flag bit 2, bits 1:0 zero
// - Bit 7 of 0xf1 switches PA supply
// - Preamp code from bits 5 and 0
// - Eight-bit PA bias at 0xf2, resets zero
// - Feedback divides by 16 or 22
// - Band bit in 0xc2 picks divide ratio
package rfxc_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam logic [7:0]  CRYSTAL_BIAS_OFS = 8'h86;
    localparam logic [7:0]  BAND_SEL_OFS     = 8'hc2;
    localparam logic [7:0]  LOCAL_STATUS_OFS = 8'he3;
    localparam logic [7:0]  IRQ_STATUS_OFS   = 8'he4;
    localparam logic [7:0]  IRQ_MASK_OFS     = 8'he5;
    localparam logic [7:0]  PA_POWER_OFS     = 8'hf1;
    localparam logic [7:0]  PA_BIAS_OFS      = 8'hf2;
    localparam int          BIAS_W           = 4;
    localparam int          XTAL_RUN_BIT     = 4;
    localparam int          VCO_GAIN_BIT     = 3;
    localparam int          LOCK_BIT         = 2;
    localparam int          PA_SUPPLY_BIT    = 7;
    localparam int          PREAMP_HI_BIT    = 5;
    localparam int          PREAMP_LO_BIT    = 0;
    localparam int          BAND_BIT         = 7;
    localparam logic [7:0]  BAND_RESET       = 8'h80;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [7:0]  UNDEF_READ       = 8'h00;
    localparam int          DIV_315          = 16;
    localparam int          DIV_434          = 22;
    localparam int          DIV_W            = 5;
    localparam int          IRQ_N            = 3;
    localparam int          BIAS_STEP_UA     = 20;
endpackage

/* core/rfxc_regs.sv */
// Crystal oscillator and RF PA control register bank
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module rfxc_regs (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       timer_rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       crystal_oscillator_in,
    input  wire logic       vco_gain_in,
    input  wire logic       pll_lock_in,
    input  wire logic       vco_div_clk_en,
    output logic      [3:0] crystal_bias_code,
    output logic            pa_supply_switch,
    output logic      [1:0] preamp_current_code,
    output logic      [7:0] pa_output_bias_value,
    output logic            band_315,
    output logic            fb_pulse,
    output logic            irq
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [3:0] bias_ff;
    logic [7:0] pwr_ff;
    logic [7:0] pab_ff;
    logic [7:0] band_ff;
    logic [7:0] rdata_ff;
    logic [2:0] stat_sync;
    logic [2:0] stat_ff;
    logic [2:0] ist_ff;
    logic [2:0] msk_ff;
    logic       irq_ff;
    logic       fb_raw;
    logic       fb_ff;
    logic       clr_all;
    logic [2:0] evt;
    logic [2:0] w1c;

    // Timer reset clears bias, PA power, PA bias, status and IRQ status; band, mask and irq clear only on power-on reset
    assign clr_all = !nrst || timer_rst;

    rfxc_sync #(.W(3)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  ({crystal_oscillator_in, vco_gain_in, pll_lock_in}),
        .dout (stat_sync)
    );

    // Divider runs free on the system clock; its pulse is gated afterwards by vco_div_clk_en
    rfxc_fbdiv u_div (
        .clk      (clk),
        .nrst     (nrst),
        .band_315 (band_ff[rfxc_pkg::BAND_BIT]),
        .fb_pulse (fb_raw)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (clr_all) begin
            bias_ff <= '0;
        end else if (wr && addr == rfxc_pkg::CRYSTAL_BIAS_OFS) begin
            bias_ff <= wdata[rfxc_pkg::BIAS_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (clr_all) begin
            pwr_ff <= rfxc_pkg::CTRL_RESET;
        end else if (wr && addr == rfxc_pkg::PA_POWER_OFS) begin
            pwr_ff <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (clr_all) begin
            pab_ff <= rfxc_pkg::CTRL_RESET;
        end else if (wr && addr == rfxc_pkg::PA_BIAS_OFS) begin
            pab_ff <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            band_ff <= rfxc_pkg::BAND_RESET;
        end else if (wr && addr == rfxc_pkg::BAND_SEL_OFS) begin
            band_ff <= wdata;
        end
    end

    // Status follows the analog flags; zero during either reset
    always_ff @(posedge clk) begin
        if (clr_all) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= stat_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Events: crystal start, lock gained, lock lost
    assign evt = {stat_sync[2] && !stat_ff[2],
                  stat_sync[0] && !stat_ff[0],
                  !stat_sync[0] && stat_ff[0]};
    assign w1c = (wr && addr == rfxc_pkg::IRQ_STATUS_OFS) ? wdata[2:0] : 3'h0;

    // Set wins over a same-cycle clear so no event is lost
    always_ff @(posedge clk) begin
        if (clr_all) begin
            ist_ff <= '0;
        end else begin
            ist_ff <= (ist_ff & ~w1c) | evt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            msk_ff <= '0;
        end else if (wr && addr == rfxc_pkg::IRQ_MASK_OFS) begin
            msk_ff <= wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(ist_ff & msk_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write-only registers read as zero; local status writes fall through unused
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
        end else if (rd) begin
            case (addr)
                rfxc_pkg::LOCAL_STATUS_OFS: rdata_ff <= {3'h0, stat_ff, 2'h0};
                rfxc_pkg::IRQ_STATUS_OFS:   rdata_ff <= {5'h00, ist_ff};
                rfxc_pkg::IRQ_MASK_OFS:     rdata_ff <= {5'h00, msk_ff};
                default:                    rdata_ff <= rfxc_pkg::UNDEF_READ;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fb_ff <= 1'b0;
        end else begin
            fb_ff <= fb_raw && vco_div_clk_en;
        end
    end

    assign rdata                = rdata_ff;
    assign crystal_bias_code    = bias_ff;
    assign pa_supply_switch     = pwr_ff[rfxc_pkg::PA_SUPPLY_BIT];
    assign preamp_current_code  = {pwr_ff[rfxc_pkg::PREAMP_HI_BIT], pwr_ff[rfxc_pkg::PREAMP_LO_BIT]};
    assign pa_output_bias_value = pab_ff;
    assign band_315             = band_ff[rfxc_pkg::BAND_BIT];
    assign fb_pulse             = fb_ff;
    assign irq                  = irq_ff;
endmodule
`default_nettype wire

/* core/rfxc_sync.sv */
// Two-flop synchroniser for the analog status inputs
`timescale 1ns/10ps
`default_nettype none
module rfxc_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

/* tb/rfxc_regs_assertions.sv */
// Checker for the crystal and PA register bank ports
`timescale 1ns/10ps
`default_nettype none
module rfxc_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       timer_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [3:0] crystal_bias_code,
    input wire logic       pa_supply_switch,
    input wire logic [1:0] preamp_current_code,
    input wire logic [7:0] pa_output_bias_value,
    input wire logic       band_315
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Timer reset outranks a write in the same cycle
    wire logic       w_ok = wr && !timer_rst;
    logic      [7:0] wdata_ff;
    always_ff @(posedge clk) wdata_ff <= wdata;
    ////////////////////////////////////////////////////////////
    a_bias_write: assert property (w_ok && addr == 8'h86 |=> crystal_bias_code == wdata_ff[3:0])
        else $error("bias code differs from write");
    a_supply_write: assert property (w_ok && addr == 8'hf1 |=> pa_supply_switch == wdata_ff[7])
        else $error("supply switch differs from write");
    a_preamp_write: assert property (w_ok && addr == 8'hf1 |=> preamp_current_code == {wdata_ff[5], wdata_ff[0]})
        else $error("preamp code differs from write");
    a_bias_byte: assert property (w_ok && addr == 8'hf2 |=> pa_output_bias_value == wdata_ff)
        else $error("pa bias differs from write");
    a_band_write: assert property (w_ok && addr == 8'hc2 |=> band_315 == wdata_ff[7])
        else $error("band bit differs from write");
    a_band_keep: assert property (timer_rst && !wr |=> $stable(band_315))
        else $error("band changed by timer reset");
    a_timer_clear: assert property (timer_rst |=> crystal_bias_code == 4'h0 && !pa_supply_switch
        && pa_output_bias_value == 8'h00)
        else $error("timer reset left control set");
    a_status_rsvd: assert property (rd && addr == 8'he3 |=> rdata[1:0] == 2'h0 && rdata[7:5] == 3'h0)
        else $error("status reserved bits set");
    a_wo_read: assert property (rd && addr inside {8'h86, 8'hf1, 8'hf2} |=> rdata == 8'h00)
        else $error("write-only read not zero");
    c_supply: cover property (w_ok && addr == 8'hf1);
    c_timer: cover property (timer_rst);
    c_status: cover property (rd && addr == 8'he3);
endmodule
bind rfxc_regs rfxc_chk u_chk (.clk, .nrst, .timer_rst, .addr, .wdata, .wr, .rd, .rdata, .crystal_bias_code,
    .pa_supply_switch, .preamp_current_code, .pa_output_bias_value, .band_315);
`default_nettype wire

/* tb/rfxc_regs_bench.sv */
// Self-checking bench for the crystal and PA register bank
`timescale 1ns/10ps
`default_nettype none
module rfxc_regs_bench;
    logic        clk = '0, nrst = '0, trst = '0, wr = '0, rd = '0, xo = '0, vg = '0, lk = '0, en = '0;
    logic [7:0]  addr = '0, wd = '0, rdata, pab;
    logic [3:0]  bias;
    logic [1:0]  pre;
    logic        pa, band, fb, irq;
    int          failures = 0, checks_done = 0, n;
    logic [31:0] r = 32'h1477;
    always #5 clk = ~clk;
    rfxc_regs dut (.clk, .nrst, .timer_rst(trst), .addr, .wdata(wd), .wr, .rd, .rdata,
        .crystal_oscillator_in(xo), .vco_gain_in(vg), .pll_lock_in(lk), .vco_div_clk_en(en),
        .crystal_bias_code(bias), .pa_supply_switch(pa), .preamp_current_code(pre),
        .pa_output_bias_value(pab), .band_315(band), .fb_pulse(fb), .irq);
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string s, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wd <= d;
        cyc(1);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, e);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        cyc(1);
        rd <= 1'h0;
        chk("rdata", rdata, e);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog: the tests need about 950 cycles
    initial begin
        #300000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        cyc(1);
        chk("band", {7'h0, band}, 8'h01);
        chk("ctrl", {pa, 1'h0, pre, bias}, 8'h00);
        chk("pab", pab, 8'h00);
        rd_reg(8'he3, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            r = lfsr(r);
            wr_reg(8'h86, r[7:0]);
            // Preamp code stepped so every current level is set
            wr_reg(8'hf1, {r[15:14], i[1], r[12:9], i[0]});
            wr_reg(8'hf2, r[23:16]);
            wr_reg(8'hc2, r[31:24]);
            chk("ctrl", {pa, 1'h0, pre, bias}, {r[15], 1'h0, i[1:0], r[3:0]});
            chk("pab", pab, r[23:16]);
            chk("band", {7'h0, band}, {7'h0, r[31]});
            rd_reg(8'h86, 8'h00);
            rd_reg(8'hf1, 8'h00);
            rd_reg(8'hf2, 8'h00);
        end
        $display("control test done");
        @(posedge clk);
        xo <= 1'h1;
        lk <= 1'h1;
        vg <= 1'h1;
        cyc(5);
        rd_reg(8'he3, 8'h1c);
        wr_reg(8'he3, 8'hff);
        vg <= 1'h0;
        cyc(5);
        rd_reg(8'he3, 8'h14);
        rd_reg(8'he4, 8'h06);
        chk("irq", {7'h0, irq}, 8'h00);
        wr_reg(8'he5, 8'h02);
        cyc(2);
        chk("irq", {7'h0, irq}, 8'h01);
        wr_reg(8'he4, 8'h06);
        cyc(2);
        chk("irq", {7'h0, irq}, 8'h00);
        rd_reg(8'he4, 8'h00);
        $display("status test done");
        wr_reg(8'hf1, 8'ha1);
        wr_reg(8'hf2, 8'ha5);
        @(posedge clk);
        trst <= 1'h1;
        cyc(1);
        trst <= 1'h0;
        chk("ctrl", {pa, 1'h0, pre, bias}, 8'h00);
        chk("pab", pab, 8'h00);
        chk("band", {7'h0, band}, {7'h0, r[31]});
        $display("timer reset test done");
        en <= 1'h1;
        for (int b = 0; b < 2; b++) begin
            wr_reg(8'hc2, {b[0], 7'h00});
            cyc(30);
            n = 0;
            repeat (352) begin
                cyc(1);
                n += int'(fb);
            end
            chk("pulses", 8'(n), b ? 8'h16 : 8'h10);
        end
        $display("divider test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
